/* core/tcf_top.sv */
// Tag command decoder, session state machine and answer sender
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module tcf_top import tcf_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Request byte stream
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_end,
    // Answer byte stream
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic tx_last,
    input wire logic tx_ready
);
    function automatic logic cmd_is(input logic [2:0] len, input logic [2:0] want,
                                    input logic [7:0] b, input logic [7:0] code);
        return (len == want) && (b == code);
    endfunction : cmd_is

    function automatic logic [7:0] blk_idx(input logic [7:0] a);
        return (a == SYS_BLOCK) ? SYS_IDX : {1'b0, a[6:0]};
    endfunction : blk_idx

    tcf_state_t st_r, st_nxt;
    tcf_tx_t tx_st_r;
    logic [7:0] req_r [0:3];
    logic [2:0] len_r;
    logic [7:0] sid_r, sid_nxt;
    logic [15:0] lfsr_r;
    logic [31:0] mem [0:NUM_BLK-1];
    logic ctrl_en_r;
    logic [7:0] maddr_r;
    logic [7:0] turn_r;
    logic [2:0] idx_r;
    logic four_r;
    logic [31:0] word_r;
    logic [15:0] crc_rx, crc_tx;
    logic ans, ans_four;
    logic [31:0] ans_word;

    // Request capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            len_r <= 3'h0;
        end else if (rx_end) begin
            len_r <= 3'h0;
        end else if (rx_valid && len_r != LEN_OVER) begin
            len_r <= len_r + 3'h1;
        end
    end

    always_ff @(posedge pclk) begin
        if (rx_valid && !rx_end && len_r < LEN_LONG) begin
            req_r[len_r[1:0]] <= rx_data;
        end
    end

    tcf_crc16 u_crc_rx (
        .pclk(pclk),
        .presetn(presetn),
        .clr(rx_end),
        .en(rx_valid),
        .din(rx_data),
        .crc(crc_rx)
    );

    // Frame acceptance
    wire busy = tx_st_r != TX_IDLE;
    wire crc_ok = crc_rx == CRC_RESID;
    wire go = rx_end && crc_ok && ctrl_en_r && !busy && st_r != ST_RETIRED;
    wire [7:0] op = req_r[0];
    wire [7:0] prm = req_r[1];
    wire is_init = cmd_is(len_r, LEN_LONG, op, CMD_ANTI) && prm == PRM_BEGIN;
    wire is_poll = cmd_is(len_r, LEN_LONG, op, CMD_ANTI) && prm == PRM_POLL;
    wire is_slot = len_r == LEN_SHORT && op[3:0] == SLOT_CODE && op[7:4] != SLOT_ZERO;
    wire is_bind = cmd_is(len_r, LEN_LONG, op, CMD_BIND);
    wire is_fin = cmd_is(len_r, LEN_SHORT, op, CMD_FINISH);
    wire is_rtc = cmd_is(len_r, LEN_SHORT, op, CMD_RTC);
    wire is_read = cmd_is(len_r, LEN_LONG, op, CMD_FETCH);
    wire addr_ok = !prm[7] || prm == SYS_BLOCK;
    wire sid_hit = prm == sid_r;
    wire slot_hit = op[7:4] == sid_r[3:0];
    wire [31:0] blk_word = mem[blk_idx(prm)];

    // APB decode
    wire apb_acc = psel && penable && !pready;
    wire apb_wr = psel && penable && pready && pwrite;
    wire hit_ctrl = paddr == REG_CTRL;
    wire hit_stat = paddr == REG_STATUS;
    wire hit_madr = paddr == REG_MADDR;
    wire hit_mdat = paddr == REG_MDATA;
    wire hit_seed = paddr == REG_SEED;
    wire mapped = hit_ctrl || hit_stat || hit_madr || hit_mdat || hit_seed;
    wire soft_rst = apb_wr && hit_ctrl && pwdata[CTRL_FRST_BIT];
    wire [31:0] stat_word = {16'h0, sid_r, 5'h0, 3'(st_r)};
    wire [31:0] rd_word = hit_ctrl ? {31'h0, ctrl_en_r} :
                          hit_stat ? stat_word :
                          hit_madr ? {24'h0, maddr_r} :
                          hit_mdat ? mem[blk_idx(maddr_r)] :
                          hit_seed ? {16'h0, lfsr_r} : 32'h0;
    wire [15:0] seed_val = (pwdata[15:0] == 16'h0) ? LFSR_RST : pwdata[15:0];
    wire [15:0] lfsr_nxt = lfsr_r[0] ? ((lfsr_r >> 1) ^ LFSR_TAPS) : (lfsr_r >> 1);

    // Session state machine
    always_comb begin
        st_nxt = st_r;
        sid_nxt = sid_r;
        ans = 1'b0;
        ans_four = 1'b0;
        ans_word = {24'h0, sid_r};
        if (soft_rst) begin
            st_nxt = ST_READY;
        end else if (go) begin
            case (st_r)
                ST_READY: begin
                    if (is_init) begin
                        st_nxt = ST_CENSUS;
                        sid_nxt = lfsr_r[7:0];
                        ans = 1'b1;
                        ans_word = {24'h0, lfsr_r[7:0]};
                    end
                end
                ST_CENSUS: begin
                    if (is_poll) begin
                        sid_nxt = {sid_r[7:4], lfsr_r[3:0]};
                        ans = lfsr_r[3:0] == SLOT_ZERO;
                        ans_word = {24'h0, sid_r[7:4], lfsr_r[3:0]};
                    end else if (is_slot) begin
                        ans = slot_hit;
                    end else if (is_bind && sid_hit) begin
                        st_nxt = ST_BOUND;
                        ans = 1'b1;
                    end
                end
                ST_BOUND: begin
                    if (is_bind) begin
                        ans = sid_hit;
                        st_nxt = sid_hit ? ST_BOUND : ST_UNBOUND;
                    end else if (is_fin) begin
                        st_nxt = ST_RETIRED;
                    end else if (is_rtc) begin
                        st_nxt = ST_CENSUS;
                    end else if (is_read && addr_ok) begin
                        ans = 1'b1;
                        ans_four = 1'b1;
                        ans_word = blk_word;
                    end
                end
                ST_UNBOUND: begin
                    if (is_bind && sid_hit) begin
                        st_nxt = ST_BOUND;
                        ans = 1'b1;
                    end
                end
                default: begin
                    st_nxt = st_r;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_READY;
            sid_r <= 8'h0;
        end else begin
            st_r <= st_nxt;
            sid_r <= sid_nxt;
        end
    end

    // Random source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lfsr_r <= LFSR_RST;
        end else if (apb_wr && hit_seed) begin
            lfsr_r <= seed_val;
        end else begin
            lfsr_r <= lfsr_nxt;
        end
    end

    // Register file
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_r <= CTRL_EN_RST;
            maddr_r <= 8'h0;
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_acc;
            if (apb_acc) begin
                prdata <= pwrite ? 32'h0 : rd_word;
                pslverr <= !mapped;
            end
            if (apb_wr && hit_ctrl) begin
                ctrl_en_r <= pwdata[CTRL_EN_BIT];
            end
            if (apb_wr && hit_madr) begin
                maddr_r <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge pclk) begin
        if (apb_wr && hit_mdat) begin
            mem[blk_idx(maddr_r)] <= pwdata;
        end
    end

    // Answer sender
    wire [2:0] pay = four_r ? PAY4 : PAY1;
    wire [2:0] last_idx = four_r ? LAST4 : LAST1;
    wire [7:0] crc_lo = ~crc_tx[7:0];
    wire [7:0] crc_hi = ~crc_tx[15:8];
    wire [7:0] tx_sel = (idx_r < pay) ? word_r[{idx_r[1:0], 3'h0} +: 8] :
                        (idx_r == pay) ? crc_lo : crc_hi;
    wire tx_hs = tx_valid && tx_ready;

    tcf_crc16 u_crc_tx (
        .pclk(pclk),
        .presetn(presetn),
        .clr(tx_st_r == TX_IDLE),
        .en(tx_hs && idx_r < pay),
        .din(tx_data),
        .crc(crc_tx)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_st_r <= TX_IDLE;
            turn_r <= 8'h0;
            idx_r <= 3'h0;
            four_r <= 1'b0;
            word_r <= 32'h0;
            tx_data <= 8'h0;
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
        end else begin
            case (tx_st_r)
                TX_IDLE: begin
                    if (ans && !soft_rst) begin
                        tx_st_r <= TX_WAIT;
                        turn_r <= TURN_CNT;
                        idx_r <= 3'h0;
                        four_r <= ans_four;
                        word_r <= ans_word;
                    end
                end
                TX_WAIT: begin
                    if (turn_r == 8'h0) begin
                        tx_st_r <= TX_LOAD;
                    end else begin
                        turn_r <= turn_r - 8'h1;
                    end
                end
                TX_LOAD: begin
                    tx_data <= tx_sel;
                    tx_valid <= 1'b1;
                    tx_last <= idx_r == last_idx;
                    tx_st_r <= TX_SEND;
                end
                TX_SEND: begin
                    if (tx_ready) begin
                        tx_valid <= 1'b0;
                        tx_last <= 1'b0;
                        idx_r <= idx_r + 3'h1;
                        tx_st_r <= (idx_r == last_idx) ? TX_IDLE : TX_LOAD;
                    end
                end
                default: begin
                    tx_st_r <= TX_IDLE;
                end
            endcase
        end
    end

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    poll_gate_a: assert property (go && is_poll && st_r != ST_CENSUS |=> tx_st_r == TX_IDLE)
        else $error("slot poll answered outside census");
    slot_draw_a: assert property (go && is_poll && st_r == ST_CENSUS && !soft_rst
        |=> sid_r[3:0] == $past(lfsr_r[3:0]))
        else $error("slot value not drawn on poll");
    sid_hold_a: assert property (!(go && (is_poll || is_init)) |=> $stable(sid_r))
        else $error("session id changed without poll or begin");
    poll_answer_a: assert property (go && is_poll && st_r == ST_CENSUS && !soft_rst
        |=> (tx_st_r == TX_WAIT) == ($past(lfsr_r[3:0]) == SLOT_ZERO))
        else $error("poll answer does not follow slot zero");
    slot_match_a: assert property (go && is_slot && st_r == ST_CENSUS && !soft_rst
        |=> (tx_st_r == TX_WAIT) == $past(slot_hit))
        else $error("slot query answer mismatch");
    bind_enter_a: assert property (go && is_bind && sid_hit && !soft_rst
        && (st_r == ST_CENSUS || st_r == ST_UNBOUND) |=> st_r == ST_BOUND && tx_st_r == TX_WAIT)
        else $error("matching bind did not bind");
    bind_miss_a: assert property (go && is_bind && !sid_hit && st_r == ST_BOUND && !soft_rst
        |=> st_r == ST_UNBOUND && tx_st_r == TX_IDLE)
        else $error("mismatching bind did not unbind");
    retired_lock_a: assert property (st_r == ST_RETIRED && !soft_rst
        |=> st_r == ST_RETIRED && tx_st_r == TX_IDLE)
        else $error("retired tag left its state");
    fetch_gate_a: assert property (go && is_read && (st_r != ST_BOUND || !addr_ok)
        |=> tx_st_r == TX_IDLE)
        else $error("block fetch answered when not allowed");
    turn_wait_a: assert property ($rose(tx_st_r == TX_WAIT) |-> !tx_valid [*8])
        else $error("answer started before turnaround");
    ready_quiet_a: assert property (go && st_r == ST_READY && !is_init |=> tx_st_r == TX_IDLE)
        else $error("ready tag answered a non-begin command");
endmodule : tcf_top

/* core/tcf_pkg.sv */
// Constants and types of the tag command decoder
package tcf_pkg;
    // Timing
    localparam int CLK_NS = 4;
    localparam int TURN_NS = 80;
    localparam int TURN_CYC = (TURN_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] TURN_CNT = 8'(TURN_CYC);
    // Command codes
    localparam logic [7:0] CMD_ANTI = 8'h06;
    localparam logic [7:0] PRM_BEGIN = 8'h00;
    localparam logic [7:0] PRM_POLL = 8'h04;
    localparam logic [7:0] CMD_BIND = 8'h0e;
    localparam logic [7:0] CMD_FINISH = 8'h0f;
    localparam logic [7:0] CMD_RTC = 8'h0c;
    localparam logic [7:0] CMD_FETCH = 8'h08;
    localparam logic [3:0] SLOT_CODE = 4'h6;
    localparam logic [3:0] SLOT_ZERO = 4'h0;
    // Block addressing
    localparam logic [7:0] SYS_BLOCK = 8'hff;
    localparam logic [7:0] SYS_IDX = 8'h80;
    localparam int NUM_BLK = 129;
    // Frame lengths including checksum
    localparam logic [2:0] LEN_SHORT = 3'h3;
    localparam logic [2:0] LEN_LONG = 3'h4;
    localparam logic [2:0] LEN_OVER = 3'h5;
    // Answer byte indexes
    localparam logic [2:0] PAY1 = 3'h1;
    localparam logic [2:0] PAY4 = 3'h4;
    localparam logic [2:0] LAST1 = 3'h2;
    localparam logic [2:0] LAST4 = 3'h5;
    // Checksum
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_RESID = 16'hf0b8;
    // Random source
    localparam logic [15:0] LFSR_TAPS = 16'hb400;
    localparam logic [15:0] LFSR_RST = 16'hace1;
    // Register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MADDR = 8'h08;
    localparam logic [7:0] REG_MDATA = 8'h0c;
    localparam logic [7:0] REG_SEED = 8'h10;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_FRST_BIT = 1;
    localparam logic CTRL_EN_RST = 1'b1;
    // States
    typedef enum logic [2:0] {ST_READY, ST_CENSUS, ST_BOUND, ST_UNBOUND, ST_RETIRED} tcf_state_t;
    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_LOAD, TX_SEND} tcf_tx_t;
endpackage : tcf_pkg

/* core/tcf_crc16.sv */
// Byte-wise reflected CRC-16 accumulator
`timescale 1ns/1ps
module tcf_crc16 import tcf_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic clr,
    input wire logic en,
    input wire logic [7:0] din,
    // Result
    output logic [15:0] crc
);
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_step

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc <= CRC_INIT;
        end else if (clr) begin
            crc <= CRC_INIT;
        end else if (en) begin
            crc <= crc_step(crc, din);
        end
    end
endmodule : tcf_crc16

/* verification/tcf_reader.sv */
// Reader model: sends framed requests and collects framed answers
`timescale 1ns/1ps
module tcf_reader (
    // Clock
    input wire logic pclk,
    // Request stream
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_end,
    // Answer stream
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready
);
    logic slow = 1'b0;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        rx_end = 1'b0;
        tx_ready = 1'b1;
    end
    // Reflected checksum, complemented at the end
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int k = 0; k < 8; k++) begin
                c = c[0] ? ((c >> 1) ^ 16'h8408) : (c >> 1);
            end
        end
        return ~c;
    endfunction : crc16
    // One request frame, then the answer payload if any
    task automatic xfer(input logic [7:0] req[$], input bit bad, output logic [7:0] ans[$],
                        output bit crc_ok);
        logic [15:0] c;
        bit got_last;
        got_last = 1'b0;
        c = crc16(req) ^ (bad ? 16'h0001 : 16'h0000);
        req.push_back(c[7:0]);
        req.push_back(c[15:8]);
        ans = {};
        foreach (req[i]) begin
            @(posedge pclk);
            rx_data <= req[i];
            rx_valid <= 1'b1;
        end
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_end <= 1'b1;
        rx_data <= ~req[req.size()-1];
        @(posedge pclk);
        rx_end <= 1'b0;
        for (int n = 0; n < 300; n++) begin
            @(posedge pclk);
            if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
                ans.push_back(tx_data);
                if (tx_last === 1'b1) begin
                    got_last = 1'b1;
                    break;
                end
            end
            if (ans.size() == 0 && n > 40) break;
            tx_ready <= slow ? ~tx_ready : 1'b1;
        end
        tx_ready <= 1'b1;
        crc_ok = 1'b0;
        if (ans.size() >= 3) begin
            c = {ans[ans.size()-1], ans[ans.size()-2]};
            ans = ans[0:ans.size()-3];
            crc_ok = got_last && (crc16(ans) === c);
        end
    endtask : xfer
endmodule : tcf_reader

/* verification/tcf_top_tb.sv */
// Self-checking bench for the tag command decoder
`timescale 1ns/1ps
module tcf_top_tb import tcf_pkg::*;;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, rx_valid, rx_end, tx_valid, tx_last, tx_ready;
    logic [7:0] rx_data, tx_data, sid;
    logic [31:0] rd;
    logic err;
    logic [7:0] ans[$];
    bit ok;
    int n_fail = 0;
    int compares = 0;
    always #2 pclk = ~pclk;
    tcf_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));
    tcf_reader rdr (.pclk(pclk), .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic summarize();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic st(input logic [2:0] exp);
        apb(1'b0, REG_STATUS, 32'h0);
        check("state", {29'h0, rd[2:0]}, {29'h0, exp});
        check("status err", {31'h0, err}, 32'h0);
    endtask : st
    task automatic quiet(input logic [7:0] q[$]);
        rdr.xfer(q, 1'b0, ans, ok);
        check("silent", ans.size(), 32'h0);
    endtask : quiet
    task automatic one(input logic [7:0] q[$], input logic [7:0] exp);
        rdr.xfer(q, 1'b0, ans, ok);
        check("id count", ans.size(), 32'h1);
        check("id", {24'h0, ans[0]}, {24'h0, exp});
        check("id crc", {31'h0, ok}, 32'h1);
    endtask : one
    task automatic fetch(input logic [7:0] a, input logic [31:0] exp);
        rdr.xfer({CMD_FETCH, a}, 1'b0, ans, ok);
        check("fetch count", ans.size(), 32'h4);
        for (int i = 0; i < 4; i++) begin
            check("fetch byte", {24'h0, ans[i]}, {24'h0, exp[8*i+:8]});
        end
        check("fetch crc", {31'h0, ok}, 32'h1);
    endtask : fetch
    task automatic t_ready();
        st(ST_READY);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped", {31'h0, err}, 32'h1);
        quiet({CMD_ANTI, PRM_POLL});
        quiet({CMD_FETCH, 8'h00});
        st(ST_READY);
    endtask : t_ready
    task automatic t_census();
        rdr.xfer({CMD_ANTI, PRM_BEGIN}, 1'b0, ans, ok);
        apb(1'b0, REG_STATUS, 32'h0);
        sid = rd[15:8];
        check("begin count", ans.size(), 32'h1);
        check("begin id", {24'h0, ans[0]}, {24'h0, sid});
        check("census", {29'h0, rd[2:0]}, {29'h0, ST_CENSUS});
        rdr.xfer({CMD_BIND, sid}, 1'b1, ans, ok);
        check("bad crc", ans.size(), 32'h0);
        quiet({CMD_FINISH});
        quiet({CMD_RTC});
        quiet({CMD_FETCH, 8'h00});
        st(ST_CENSUS);
    endtask : t_census
    task automatic t_slots();
        logic [7:0] b;
        logic [3:0] slot;
        bit first;
        first = 1'b1;
        apb(1'b1, REG_SEED, 32'h0000000f);
        repeat (3) begin
            b = sid;
            rdr.xfer({CMD_ANTI, PRM_POLL}, 1'b0, ans, ok);
            apb(1'b0, REG_STATUS, 32'h0);
            sid = rd[15:8];
            slot = rd[11:8];
            if (first) check("seeded slot", {28'h0, slot}, 32'h0);
            first = 1'b0;
            check("id high", {28'h0, sid[7:4]}, {28'h0, b[7:4]});
            check("poll count", ans.size(), (slot == 4'h0) ? 32'h1 : 32'h0);
            if (slot == 4'h0) check("poll id", {24'h0, ans[0]}, {24'h0, sid});
            for (int i = 1; i < 16; i++) begin
                b = {4'(i), SLOT_CODE};
                rdr.xfer({b}, 1'b0, ans, ok);
                check("slot count", ans.size(), (4'(i) == slot) ? 32'h1 : 32'h0);
                if (4'(i) == slot) check("slot id", {24'h0, ans[0]}, {24'h0, sid});
            end
            apb(1'b0, REG_STATUS, 32'h0);
            check("slot kept", {24'h0, rd[15:8]}, {24'h0, sid});
        end
    endtask : t_slots
    task automatic t_bound();
        apb(1'b1, REG_MADDR, 32'h5);
        apb(1'b1, REG_MDATA, 32'ha1b2c3d4);
        apb(1'b1, REG_MADDR, 32'hff);
        apb(1'b1, REG_MDATA, 32'h11223344);
        one({CMD_BIND, sid}, sid);
        st(ST_BOUND);
        rdr.slow = 1'b1;
        fetch(8'h05, 32'ha1b2c3d4);
        fetch(8'hff, 32'h11223344);
        rdr.slow = 1'b0;
        quiet({CMD_FETCH, 8'h80});
        quiet({CMD_FETCH, 8'hfe});
        quiet({CMD_RTC});
        st(ST_CENSUS);
        one({CMD_BIND, sid}, sid);
        quiet({CMD_BIND, sid ^ 8'h80});
        st(ST_UNBOUND);
        one({CMD_BIND, sid}, sid);
        quiet({CMD_FINISH});
        st(ST_RETIRED);
        quiet({CMD_ANTI, PRM_BEGIN});
        quiet({CMD_FETCH, 8'h05});
        st(ST_RETIRED);
    endtask : t_bound
    task automatic t_ctrl();
        apb(1'b1, REG_CTRL, 32'h3);
        st(ST_READY);
        apb(1'b0, REG_CTRL, 32'h0);
        check("ctrl after reset", rd, 32'h1);
        apb(1'b1, REG_CTRL, 32'h0);
        apb(1'b0, REG_CTRL, 32'h0);
        check("ctrl off", rd, 32'h0);
        quiet({CMD_ANTI, PRM_BEGIN});
        st(ST_READY);
        apb(1'b1, REG_CTRL, 32'h1);
        apb(1'b0, REG_MADDR, 32'h0);
        check("maddr", rd, 32'hff);
        apb(1'b0, REG_MDATA, 32'h0);
        check("mdata", rd, 32'h11223344);
        rdr.xfer({CMD_ANTI, PRM_BEGIN}, 1'b0, ans, ok);
        check("rebegin count", ans.size(), 32'h1);
        check("rebegin crc", {31'h0, ok}, 32'h1);
        st(ST_CENSUS);
    endtask : t_ctrl
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_ready();
        t_census();
        t_slots();
        t_bound();
        t_ctrl();
        summarize();
    end
    initial begin
        #200000;
        n_fail++;
        summarize();
    end
endmodule : tcf_top_tb
